//--- src/srst_map.svh
`ifndef SRST_MAP_SVH
`define SRST_MAP_SVH
// ----------------------------------------
// Instruction field positions
// ----------------------------------------
`define SRST_OP_HI       31
`define SRST_OP_LO       30
`define SRST_RD_HI       29
`define SRST_RD_LO       25
`define SRST_COND_HI     28
`define SRST_COND_LO     25
`define SRST_OPX_HI      24
`define SRST_OPX_LO      19
`define SRST_SRC1_HI     18
`define SRST_SRC1_LO     14
`define SRST_IMM_BIT     13
`define SRST_SIMM_HI     12
`define SRST_SRC2_HI     4
`define SRST_SRC2_LO     0
// ----------------------------------------
// Opcode values
// ----------------------------------------
`define SRST_OP_ARITH    2'h2
`define SRST_OPX_TRAP    6'h3a
`define SRST_OPX_RDAUX   6'h28
`define SRST_OPX_RDPS    6'h29
`define SRST_OPX_RDWG    6'h2a
`define SRST_OPX_RDTB    6'h2b
`define SRST_OPX_WRAUX   6'h30
`define SRST_OPX_WRPS    6'h31
`define SRST_OPX_WRWG    6'h32
`define SRST_OPX_WRTB    6'h33
`define SRST_ASR_FENCE   5'h0f
`define SRST_ASR_IMPL    5'h10
// ----------------------------------------
// Status word layout and values
// ----------------------------------------
`define SRST_PS_WP_HI    4
`define SRST_PS_WP_LO    0
`define SRST_PS_TE       5
`define SRST_PS_PS       6
`define SRST_PS_SV       7
`define SRST_PS_IL_HI    11
`define SRST_PS_IL_LO    8
`define SRST_PS_C        20
`define SRST_PS_V        21
`define SRST_PS_Z        22
`define SRST_PS_N        23
`define SRST_PS_WMASK    32'h00f00fff
`define SRST_PS_RESET    32'h00000080
`define SRST_TB_WMASK    32'hfffff000
`define SRST_TTYPE_HI    11
`define SRST_TTYPE_LO    4
`define SRST_TTYPE_BASE  8'h80
`define SRST_WIN_COUNT   5'h08
`define SRST_WIN_LAST    5'h07
`define SRST_WG_WMASK    32'h000000ff
`define SRST_DELAY       2'h2
`define SRST_REG_L1      5'h11
`define SRST_REG_L2      5'h12
`define SRST_ZERO32      32'h00000000
`endif

//--- src/srst_pkg.sv
package srst_pkg;
  typedef enum logic [2:0] {
    SRST_EXC_NONE, SRST_EXC_SWTRAP, SRST_EXC_PRIV, SRST_EXC_ILLEGAL
  } srst_exc_type;
  typedef enum logic [2:0] {
    SRST_TGT_Y, SRST_TGT_PS, SRST_TGT_WG, SRST_TGT_TB, SRST_TGT_ASR
  } srst_tgt_type;
  // One issued instruction with its operand values
  typedef struct packed {
    logic        valid;
    logic [31:0] word;
    logic [31:0] src1;
    logic [31:0] src2;
    logic [31:0] pc;
    logic [31:0] next_fetch_addr;
  } srst_issue_type;
  // A general register write request
  typedef struct packed {
    logic        valid;
    logic [4:0]  index;
    logic [31:0] data;
  } srst_gpr_wr_type;
  // A pending delayed state write
  typedef struct packed {
    logic         valid;
    srst_tgt_type tgt;
    logic [1:0]   left;
    logic [31:0]  data;
  } srst_pend_type;
endpackage : srst_pkg

//--- src/srst_exec.sv
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`include "srst_map.svh"
// Function
// RQ1 - Conditional trap tests flags; true with nothing pending raises software trap.
// RQ2 - False trap test raises nothing and acts as a no-op.
// RQ3 - Trap type is 128 plus low seven bits of the operand sum.
// RQ4 - Taken trap: supervisor, traps off, window down, save PC and next PC.
// RQ5 - State reads copy the chosen state register into the destination.
// RQ6 - Read extension 0x28 with src1 zero reads aux multiply, else ancillary.
// RQ7 - Ancillary reads 1..14 give undefined data, never an illegal exception.
// RQ8 - Ancillary read 15 with destination zero is the store fence.
// RQ9 - Ancillary reads 16..31 behaviour is chosen by this design.
// RQ10 - Status, window guard and trap base reads are privileged.
// RQ11 - State writes store src1 xor operand into writable fields only.
// RQ12 - Write extension 0x30 with destination zero writes aux multiply.
// RQ13 - Ancillary writes 1..15 are reserved with undefined results.
// RQ14 - Ancillary writes 16..31 are design choice; never touch aux multiply.
// RQ15 - Status write to unimplemented window raises illegal, status unchanged.
// RQ16 - State writes land after a fixed delay of zero to three instructions.
// RQ17 - New trap enable and level mask act on interrupts immediately.
// RQ18 - Overlapping writes to one field are undefined except repeated same write.
// RQ19 - Reading a changed field within three instructions may be undefined.
// RQ20 - Software avoids window moves shortly after a window guard change.
// RQ21 - Status, window guard and trap base writes are privileged.
// RQ22 - Test select decodes always, never, not-equal and the flag tests.
// RQ23 - Privileged access outside supervisor raises privilege, changes nothing.
module srst_exec (
  input  wire logic                     clock_i,       // 25 MHz core clock
  input  wire logic                     reset_n_i,     // Async reset, active low
  input  wire srst_pkg::srst_issue_type issue_i,       // Instruction to execute
  input  wire logic                     exc_pending_i, // Higher priority event pending
  output srst_pkg::srst_gpr_wr_type     gpr_wr_o,      // General register write
  output srst_pkg::srst_gpr_wr_type     gpr_wr2_o,     // Second register write
  output srst_pkg::srst_exc_type        exc_o,         // Exception raised
  output logic                          fence_o,       // Store fence pulse
  output logic [31:0]                   proc_status_o, // Status register
  output logic [31:0]                   window_guard_o,// Window guard mask
  output logic [31:0]                   trap_base_o,   // Trap base register
  output logic [31:0]                   aux_mult_o,    // Aux multiply register
  output logic                          trap_enable_o, // Effective trap enable
  output logic [3:0]                    interrupt_level_mask_o // Effective level mask
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Sign extend a 13 bit immediate
  function automatic logic [31:0] sext13(input logic [12:0] v);
    sext13 = {{19{v[12]}}, v};
  endfunction : sext13

  // Window pointer minus one, modulo window count
  function automatic logic [4:0] win_dec(input logic [4:0] w);
    win_dec = (w == 5'h00) ? `SRST_WIN_LAST : w - 5'h01;
  endfunction : win_dec

  // Merge writable bits only
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [31:0] mask);
    merge = (old_v & ~mask) | (new_v & mask);
  endfunction : merge

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [31:0]             proc_status_r;
  logic [31:0]             window_guard_r;
  logic [31:0]             trap_base_r;
  logic [31:0]             aux_mult_r;
  srst_pkg::srst_pend_type pend_r;
  srst_pkg::srst_pend_type pend_nxt;
  logic                    imm_te_r;
  logic [3:0]              imm_il_r;
  srst_pkg::srst_gpr_wr_type gpr_wr_r;
  srst_pkg::srst_gpr_wr_type gpr_wr2_r;
  srst_pkg::srst_exc_type  exc_r;
  logic                    fence_r;

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  wire logic [31:0] w      = issue_i.word;
  wire logic        is_f3  = issue_i.valid && (w[`SRST_OP_HI:`SRST_OP_LO] == `SRST_OP_ARITH);
  wire logic [5:0]  opx    = w[`SRST_OPX_HI:`SRST_OPX_LO];
  wire logic [4:0]  rd     = w[`SRST_RD_HI:`SRST_RD_LO];
  wire logic [4:0]  src1_idx = w[`SRST_SRC1_HI:`SRST_SRC1_LO];
  wire logic [3:0]  cond   = w[`SRST_COND_HI:`SRST_COND_LO];
  wire logic        use_imm = w[`SRST_IMM_BIT];
  wire logic [31:0] opnd2  = use_imm ? sext13(w[`SRST_SIMM_HI:0]) : issue_i.src2;
  wire logic        sup    = proc_status_r[`SRST_PS_SV];
  wire logic        flag_n = proc_status_r[`SRST_PS_N];
  wire logic        flag_z = proc_status_r[`SRST_PS_Z];
  wire logic        flag_v = proc_status_r[`SRST_PS_V];
  wire logic        flag_c = proc_status_r[`SRST_PS_C];

  // Opcode groups
  wire logic is_trap = is_f3 && (opx == `SRST_OPX_TRAP);
  wire logic is_rd28 = is_f3 && (opx == `SRST_OPX_RDAUX);
  wire logic is_rdp  = is_f3 && (opx == `SRST_OPX_RDPS || opx == `SRST_OPX_RDWG ||
                                 opx == `SRST_OPX_RDTB);
  wire logic is_wr30 = is_f3 && (opx == `SRST_OPX_WRAUX);
  wire logic is_wrp  = is_f3 && (opx == `SRST_OPX_WRPS || opx == `SRST_OPX_WRWG ||
                                 opx == `SRST_OPX_WRTB);

  // ----------------------------------------
  // Condition test
  // ----------------------------------------
  // RQ22 test select decode
  logic cond_base;
  always_comb begin
    unique case (cond[2:0])
      3'h0: cond_base = 1'b0;
      3'h1: cond_base = flag_z;
      3'h2: cond_base = flag_z | (flag_n ^ flag_v);
      3'h3: cond_base = flag_n ^ flag_v;
      3'h4: cond_base = flag_c | flag_z;
      3'h5: cond_base = flag_c;
      3'h6: cond_base = flag_n;
      3'h7: cond_base = flag_v;
    endcase
  end
  // Upper half of the codes inverts the lower half
  wire logic cond_true = cond[3] ^ cond_base;

  // RQ1 trap raised only with nothing pending
  // RQ2 false test is a no-op
  wire logic trap_take = is_trap && cond_true && !exc_pending_i;
  // RQ3 trap type from operand sum
  wire logic [31:0] trap_sum = issue_i.src1 + opnd2;
  wire logic [7:0]  trap_tt  = `SRST_TTYPE_BASE | {1'b0, trap_sum[6:0]};

  // ----------------------------------------
  // Privilege and legality
  // ----------------------------------------
  // RQ10 privileged reads, RQ21 privileged writes
  wire logic priv_fault = (is_rdp || is_wrp) && !sup;
  // RQ8 store fence decode, RQ7 reserved reads never trap
  wire logic fence_hit  = is_rd28 && (src1_idx == `SRST_ASR_FENCE) && (rd == 5'h00);
  // RQ11 value is src1 xor second operand
  wire logic [31:0] wr_val = issue_i.src1 ^ opnd2;
  // RQ15 window pointer must name an implemented window
  wire logic wp_bad = is_wrp && (opx == `SRST_OPX_WRPS) &&
                      (wr_val[`SRST_PS_WP_HI:`SRST_PS_WP_LO] >= `SRST_WIN_COUNT);
  // RQ23 faulting access changes nothing
  wire logic wr_ok  = (is_wr30 || is_wrp) && !priv_fault && !wp_bad;

  // Target of an accepted write
  srst_pkg::srst_tgt_type wr_tgt;
  always_comb begin
    wr_tgt = srst_pkg::SRST_TGT_ASR;
    // RQ12 destination zero selects aux multiply
    if (is_wr30 && rd == 5'h00) wr_tgt = srst_pkg::SRST_TGT_Y;
    else if (opx == `SRST_OPX_WRPS) wr_tgt = srst_pkg::SRST_TGT_PS;
    else if (opx == `SRST_OPX_WRWG) wr_tgt = srst_pkg::SRST_TGT_WG;
    else if (opx == `SRST_OPX_WRTB) wr_tgt = srst_pkg::SRST_TGT_TB;
  end

  // ----------------------------------------
  // Read data selection
  // ----------------------------------------
  // RQ5 copy state register, RQ6 src1 picks aux or ancillary
  logic [31:0] rd_val;
  always_comb begin
    rd_val = `SRST_ZERO32;
    if (is_rd28 && src1_idx == 5'h00) rd_val = aux_mult_r;
    else if (opx == `SRST_OPX_RDPS) rd_val = proc_status_r;
    else if (opx == `SRST_OPX_RDWG) rd_val = window_guard_r;
    else if (opx == `SRST_OPX_RDTB) rd_val = trap_base_r;
    // RQ9 ancillary 16..31 read as zero, unprivileged; RQ7 1..14 also zero
  end
  wire logic rd_ok = (is_rd28 && !fence_hit && !(src1_idx == `SRST_ASR_FENCE)) ||
                     (is_rdp && !priv_fault);

  // ----------------------------------------
  // Delayed write pipeline
  // ----------------------------------------
  // RQ16 fixed delay counted in issued instructions
  // RQ18 a newer write replaces the pending one so repeats land correctly
  always_comb begin
    pend_nxt = pend_r;
    if (issue_i.valid && pend_r.valid && pend_r.left != 2'h0)
      pend_nxt.left = pend_r.left - 2'h1;
    if (pend_r.valid && pend_r.left == 2'h0)
      pend_nxt.valid = 1'b0;
    if (wr_ok && !trap_take) begin
      pend_nxt.valid = 1'b1;
      pend_nxt.tgt   = wr_tgt;
      pend_nxt.left  = `SRST_DELAY;
      pend_nxt.data  = wr_val;
    end
  end
  // RQ19 reads before landing see the old value
  wire logic land = pend_r.valid && (pend_r.left == 2'h0);

  // ----------------------------------------
  // Architectural registers
  // ----------------------------------------
  // Trap entry and delayed landing share the status register
  logic [31:0] ps_nxt;
  always_comb begin
    ps_nxt = proc_status_r;
    if (land && pend_r.tgt == srst_pkg::SRST_TGT_PS)
      ps_nxt = merge(proc_status_r, pend_r.data, `SRST_PS_WMASK);
    // RQ4 supervisor on, traps off, window down
    if (trap_take) begin
      ps_nxt[`SRST_PS_PS] = ps_nxt[`SRST_PS_SV];
      ps_nxt[`SRST_PS_SV] = 1'b1;
      ps_nxt[`SRST_PS_TE] = 1'b0;
      ps_nxt[`SRST_PS_WP_HI:`SRST_PS_WP_LO] = win_dec(ps_nxt[`SRST_PS_WP_HI:`SRST_PS_WP_LO]);
    end
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      proc_status_r  <= `SRST_PS_RESET;
      window_guard_r <= `SRST_ZERO32;
      trap_base_r    <= `SRST_ZERO32;
      aux_mult_r     <= `SRST_ZERO32;
      pend_r         <= '0;
    end else begin
      proc_status_r <= ps_nxt;
      pend_r        <= pend_nxt;
      // RQ3 trap type field load
      if (trap_take)
        trap_base_r[`SRST_TTYPE_HI:`SRST_TTYPE_LO] <= trap_tt;
      else if (land && pend_r.tgt == srst_pkg::SRST_TGT_TB)
        trap_base_r <= merge(trap_base_r, pend_r.data, `SRST_TB_WMASK);
      if (land && pend_r.tgt == srst_pkg::SRST_TGT_WG)
        window_guard_r <= pend_r.data & `SRST_WG_WMASK;
      // RQ14 ancillary writes never reach aux multiply; RQ13 ignored
      if (land && pend_r.tgt == srst_pkg::SRST_TGT_Y)
        aux_mult_r <= pend_r.data;
    end
  end

  // ----------------------------------------
  // Immediate interrupt controls
  // ----------------------------------------
  // RQ17 trap enable and level take effect at once
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      imm_te_r <= 1'b0;
      imm_il_r <= 4'h0;
    end else if (trap_take) begin
      imm_te_r <= 1'b0;
    end else if (wr_ok && wr_tgt == srst_pkg::SRST_TGT_PS) begin
      imm_te_r <= wr_val[`SRST_PS_TE];
      imm_il_r <= wr_val[`SRST_PS_IL_HI:`SRST_PS_IL_LO];
    end
  end

  // ----------------------------------------
  // Result outputs
  // ----------------------------------------
  // Exception priority: privilege, illegal, then software trap
  srst_pkg::srst_exc_type exc_nxt;
  always_comb begin
    exc_nxt = srst_pkg::SRST_EXC_NONE;
    if (priv_fault) exc_nxt = srst_pkg::SRST_EXC_PRIV;
    else if (wp_bad) exc_nxt = srst_pkg::SRST_EXC_ILLEGAL;
    else if (trap_take) exc_nxt = srst_pkg::SRST_EXC_SWTRAP;
  end

  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gpr_wr_r  <= '0;
      gpr_wr2_r <= '0;
      exc_r     <= srst_pkg::SRST_EXC_NONE;
      fence_r   <= 1'b0;
    end else begin
      exc_r   <= exc_nxt;
      fence_r <= fence_hit;
      // RQ4 save PC and next PC in new window locals
      gpr_wr_r.valid  <= trap_take || (rd_ok && rd != 5'h00);
      gpr_wr_r.index  <= trap_take ? `SRST_REG_L1 : rd;
      gpr_wr_r.data   <= trap_take ? issue_i.pc : rd_val;
      gpr_wr2_r.valid <= trap_take;
      gpr_wr2_r.index <= `SRST_REG_L2;
      gpr_wr2_r.data  <= issue_i.next_fetch_addr;
    end
  end

  assign gpr_wr_o              = gpr_wr_r;
  assign gpr_wr2_o             = gpr_wr2_r;
  assign exc_o                 = exc_r;
  assign fence_o               = fence_r;
  assign proc_status_o         = proc_status_r;
  assign window_guard_o        = window_guard_r;
  assign trap_base_o           = trap_base_r;
  assign aux_mult_o            = aux_mult_r;
  assign trap_enable_o         = imm_te_r;
  assign interrupt_level_mask_o = imm_il_r;

endmodule : srst_exec

//--- test/srst_exec_properties.sv
`timescale 1ns/1ns
// ------
// Port checks for the state access unit
// ------
module srst_exec_props (
  input wire logic                      clock_i,               // Core clock
  input wire logic                      reset_n_i,             // Reset, active low
  input wire srst_pkg::srst_issue_type  issue_i,               // Issued word
  input wire logic                      exc_pending_i,         // Pending event
  input wire srst_pkg::srst_gpr_wr_type gpr_wr_o,              // Register write
  input wire srst_pkg::srst_gpr_wr_type gpr_wr2_o,             // Second write
  input wire srst_pkg::srst_exc_type    exc_o,                 // Exception
  input wire logic                      fence_o,               // Fence pulse
  input wire logic [31:0]               proc_status_o,         // Status
  input wire logic [31:0]               trap_base_o,           // Trap base
  input wire logic                      trap_enable_o,         // Trap enable
  input wire logic [3:0]                interrupt_level_mask_o // Level mask
);
  // Decode of the issued word, shared by all checks
  wire logic [31:0] w     = issue_i.word;
  wire logic        ok    = issue_i.valid && w[31:30] == 2'h2;
  wire logic [5:0]  opx   = w[24:19];
  wire logic        sup   = proc_status_o[7];
  wire logic        trap  = ok && opx == 6'h3a && w[28:25] == 4'h8 && !exc_pending_i;
  wire logic [31:0] opnd  = w[13] ? {{19{w[12]}}, w[12:0]} : issue_i.src2;
  wire logic [31:0] xv    = issue_i.src1 ^ opnd;
  wire logic [31:0] sum   = issue_i.src1 + opnd;
  wire logic [7:0]  ttype_x = {1'b1, sum[6:0]};
  wire logic [4:0]  wp_dn = proc_status_o[4:0] == 5'h00 ? 5'h07 : proc_status_o[4:0] - 5'h01;
  wire logic [37:0] sv1   = {1'b1, 5'h11, issue_i.pc};
  wire logic [37:0] sv2   = {1'b1, 5'h12, issue_i.next_fetch_addr};
  wire logic [4:0]  ie    = {xv[5], xv[11:8]};
  wire logic [4:0]  rdi   = w[29:25];
  wire logic        priv  = ok && (opx inside {6'h29, 6'h2a, 6'h2b, 6'h31, 6'h32, 6'h33});
  wire logic        wps   = ok && opx == 6'h31 && sup;
  wire logic        rda   = ok && opx == 6'h28 && w[18:14] != 5'h00;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  a_trap_raise: assert property (trap |=> exc_o == srst_pkg::SRST_EXC_SWTRAP)
    else $error("taken trap not raised");
  a_trap_never: assert property (ok && opx == 6'h3a && w[28:25] == 4'h0
    |=> exc_o == srst_pkg::SRST_EXC_NONE && !gpr_wr_o.valid) else $error("never trap acted");
  a_trap_held: assert property (ok && opx == 6'h3a && exc_pending_i
    |=> exc_o == srst_pkg::SRST_EXC_NONE) else $error("trap taken while event pending");
  a_trap_saves: assert property (trap |=> gpr_wr_o == $past(sv1) && gpr_wr2_o == $past(sv2))
    else $error("trap save writes wrong");
  a_trap_type: assert property (trap |=> trap_base_o[11:4] == $past(ttype_x))
    else $error("trap type wrong");
  a_trap_mode: assert property (trap |=> sup && !trap_enable_o
    && proc_status_o[4:0] == $past(wp_dn)) else $error("trap mode change wrong");
  a_priv_user: assert property (priv && !sup
    |=> exc_o == srst_pkg::SRST_EXC_PRIV && !gpr_wr_o.valid) else $error("user access let through");
  a_status_bad: assert property (wps && xv[4:0] >= 5'h08
    |=> exc_o == srst_pkg::SRST_EXC_ILLEGAL) else $error("bad window accepted");
  a_status_now: assert property (wps && xv[4:0] < 5'h08
    |=> {trap_enable_o, interrupt_level_mask_o} == $past(ie)) else $error("enable or level late");
  a_fence_pulse: assert property (rda && w[18:14] == 5'h0f && rdi == 5'h00 |=> fence_o)
    else $error("fence missing");
  a_asr_legal: assert property (rda && w[18:14] < 5'h0f
    |=> exc_o != srst_pkg::SRST_EXC_ILLEGAL) else $error("reserved read trapped");
  a_read_dest: assert property (ok && opx == 6'h28 && w[18:14] == 5'h00 && rdi != 5'h00
    |=> gpr_wr_o.valid && gpr_wr_o.index == $past(rdi)) else $error("read result missing");
endmodule : srst_exec_props

//--- test/srst_exec_tb_top.sv
`timescale 1ns/1ns
module srst_exec_tb_top;
  // ------
  // Signals, clock and unit
  // ------
  logic                      clock_i       = 1'b0;         // Core clock
  logic                      reset_n_i     = 1'b0;         // Reset
  srst_pkg::srst_issue_type  issue_i       = '0;           // Issue port
  logic                      exc_pending_i = 1'b0;         // Pending event
  srst_pkg::srst_gpr_wr_type gpr_wr_o, gpr_wr2_o;          // Register writes
  srst_pkg::srst_exc_type    exc_o;                        // Exception
  logic                      fence_o, trap_enable_o;       // Pulse and enable
  logic [31:0]               proc_status_o, window_guard_o, trap_base_o, aux_mult_o;
  logic [3:0]                interrupt_level_mask_o;       // Level mask
  logic [31:0]               pc            = 32'h00001000; // Fetch address
  int                        mismatches    = 0;            // Failed compares
  int                        cmp_count     = 0;            // All compares
  int                        cycles        = 0;            // Hang guard
  localparam logic [31:0]    SRCS [3]      = '{32'h12345678, 32'h0000ffff, 32'habcde123};
  localparam logic [31:0]    EXPS [3]      = '{32'hedcba678, 32'h000000ff, 32'h54321830};
  always #20 clock_i = ~clock_i;
  srst_exec u_dut (.clock_i, .reset_n_i, .issue_i, .exc_pending_i, .gpr_wr_o, .gpr_wr2_o,
    .exc_o, .fence_o, .proc_status_o, .window_guard_o, .trap_base_o, .aux_mult_o,
    .trap_enable_o, .interrupt_level_mask_o);
  // ------
  // Access tasks
  // ------
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [31:0] f3(input logic [4:0] rd, input logic [5:0] op,
                                     input logic [4:0] src, input logic i, input logic [12:0] lo);
    return {2'h2, rd, op, src, i, lo};
  endfunction : f3
  // An idle edge, then one instruction, read just after its edge so results have landed
  task automatic ex(input logic [31:0] w, input logic [31:0] s1, input logic [31:0] s2);
    @(posedge clock_i);
    issue_i <= {1'b1, w, s1, s2, pc, pc + 32'h4};
    pc = pc + 32'h8;
    @(posedge clock_i);
    issue_i.valid <= 1'b0;
    #1;
  endtask : ex
  task automatic wps(input logic [31:0] v);
    ex(f3(5'h00, 6'h31, 5'h01, 1'b0, 13'h0000), v ^ 32'h5a5a5a5a, 32'h5a5a5a5a);
  endtask : wps
  // Two never-traps let a delayed write land
  task automatic settle();
    ex(f3(5'h00, 6'h3a, 5'h00, 1'b0, 13'h0000), 32'h0, 32'h0);
    ex(f3(5'h00, 6'h3a, 5'h00, 1'b0, 13'h0000), 32'h0, 32'h0);
    @(posedge clock_i);
    #1;
  endtask : settle
  function automatic logic tst(input logic [3:0] c, input logic [3:0] f);
    logic r;
    case (c[2:0])
      3'h0: r = 1'b0;
      3'h1: r = f[2];
      3'h2: r = f[2] | (f[3] ^ f[1]);
      3'h3: r = f[3] ^ f[1];
      3'h4: r = f[0] | f[2];
      3'h5: r = f[0];
      3'h6: r = f[3];
      default: r = f[1];
    endcase
    return r ^ c[3];
  endfunction : tst
  task automatic test_done();
    $display("compares %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // Cut a hang short
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      mismatches++;
      test_done();
    end
  end
  // ------
  // Test sequence
  // ------
  initial begin
    logic [31:0] stx;
    logic [31:0] p0;
    repeat (2) @(posedge clock_i);
    reset_n_i <= 1'b1;
    @(posedge clock_i);
    #1;
    chk({proc_status_o, aux_mult_o[7:0]}, 40'h0000008000);
    $display("test reset done");
    for (int p = 0; p < 2; p++) begin
      stx = p ? 32'h00500080 : 32'h00a003a2;
      wps(stx | 32'h0f000000);
      chk({trap_enable_o, interrupt_level_mask_o}, {stx[5], stx[11:8]});
      if (p == 0) chk(proc_status_o, 32'h00000080);
      settle();
      chk(proc_status_o, stx);
      if (p == 0) begin
        p0 = pc;
        ex(f3(5'h08, 6'h3a, 5'h01, 1'b0, 13'h0000), 32'h0000007f, 32'h00000003);
        chk(gpr_wr_o, {1'b1, 5'h11, p0});
        chk(gpr_wr2_o, {1'b1, 5'h12, p0 + 32'h4});
        chk({proc_status_o, trap_enable_o}, {32'h00a003c1, 1'b0});
        chk(trap_base_o, 32'h00000820);
      end
      for (int c = 0; c < 16; c++) begin
        ex(f3({1'b0, 4'(c)}, 6'h3a, 5'h01, 1'b1, 13'h1ffe), 32'h00000105, 32'h0);
        chk(exc_o, tst(4'(c), stx[23:20]) ? srst_pkg::SRST_EXC_SWTRAP : srst_pkg::SRST_EXC_NONE);
      end
    end
    chk(trap_base_o, 32'h00000830);
    @(posedge clock_i);
    exc_pending_i <= 1'b1;
    ex(f3(5'h08, 6'h3a, 5'h01, 1'b0, 13'h0000), 32'h0, 32'h0);
    exc_pending_i <= 1'b0;
    chk({exc_o, gpr_wr_o.valid}, {srst_pkg::SRST_EXC_NONE, 1'b0});
    $display("test trap done");
    stx = 32'h00f00a85;
    wps(stx);
    settle();
    // no window moves follow a guard write
    for (int k = 0; k < 3; k++) begin
      ex(f3(5'h00, 6'h30 + 6'(k) + 6'(k > 0), 5'h01, 1'b1, 13'h1000), SRCS[k], 32'h0);
      settle();
      ex(f3(5'h09, 6'h28 + 6'(k) + 6'(k > 0), 5'h00, 1'b0, 13'h0000), 32'h0, 32'h0);
      chk(gpr_wr_o, {1'b1, 5'h09, EXPS[k]});
    end
    ex(f3(5'h09, 6'h29, 5'h00, 1'b0, 13'h0000), 32'h0, 32'h0);
    chk(gpr_wr_o, {1'b1, 5'h09, stx});
    $display("test state access done");
    ex(f3(5'h14, 6'h30, 5'h01, 1'b0, 13'h0000), 32'h1, 32'h2);
    settle();
    chk(aux_mult_o, 32'hedcba678);
    ex(f3(5'h04, 6'h28, 5'h03, 1'b0, 13'h0000), 32'h0, 32'h0);
    chk(exc_o, srst_pkg::SRST_EXC_NONE);
    ex(f3(5'h04, 6'h28, 5'h14, 1'b0, 13'h0000), 32'h0, 32'h0);
    chk(exc_o, srst_pkg::SRST_EXC_NONE);
    ex(f3(5'h00, 6'h28, 5'h0f, 1'b0, 13'h0000), 32'h0, 32'h0);
    chk(fence_o, 1'b1);
    ex(f3(5'h03, 6'h28, 5'h0f, 1'b0, 13'h0000), 32'h0, 32'h0);
    chk({fence_o, gpr_wr_o.valid}, 2'h0);
    ex(f3(5'h00, 6'h31, 5'h00, 1'b1, 13'h0009), 32'h0, 32'h0);
    chk(exc_o, srst_pkg::SRST_EXC_ILLEGAL);
    settle();
    chk(proc_status_o, stx);
    $display("test ancillary done");
    stx = 32'h00000025;
    wps(stx);
    settle();
    for (int k = 0; k < 6; k++) begin
      ex(f3(5'h09, k < 3 ? 6'h29 + 6'(k) : 6'h2e + 6'(k), 5'h01, 1'b0, 13'h0000), 32'h1000, 32'h0);
      chk({exc_o, gpr_wr_o.valid}, {srst_pkg::SRST_EXC_PRIV, 1'b0});
    end
    settle();
    chk({proc_status_o, window_guard_o[7:0]}, {stx, 8'hff});
    chk(trap_base_o, 32'h54321830);
    ex(f3(5'h09, 6'h28, 5'h00, 1'b0, 13'h0000), 32'h0, 32'h0);
    chk(gpr_wr_o, {1'b1, 5'h09, 32'hedcba678});
    ex(f3(5'h08, 6'h3a, 5'h01, 1'b0, 13'h0000), 32'h0, 32'h0);
    chk(proc_status_o, 32'h00000084);
    $display("test privilege done");
    test_done();
  end
endmodule : srst_exec_tb_top
bind srst_exec srst_exec_props u_props (.clock_i, .reset_n_i, .issue_i, .exc_pending_i,
  .gpr_wr_o, .gpr_wr2_o, .exc_o, .fence_o, .proc_status_o, .trap_base_o, .trap_enable_o,
  .interrupt_level_mask_o);
